/* src/nv_access_regs.svh */
`ifndef NV_ACCESS_REGS_SVH
`define NV_ACCESS_REGS_SVH
// Operation
// - A falling read strobe starts a read and marks its reference instant.
// - After the settle interval, address and control are ignored while read low.
// - The data output is actively driven for as long as read is low.
// - The first bit appears only after more than 50 us from the fall.
// - Each falling shift clock edge advances to the next of 10 or 12 bits.
// - A rising read strobe makes address and control inputs accepted again.
// - Busy rises at the rewrite start and stays high throughout the rewrite.
// - While busy, address, read strobe and program strobe are ignored.
// - New data is shifted in more than 50 us after the rewrite start.
// - Serial input data is sampled on each falling shift clock edge.
// - The timed write starts after the last bit and the erase are done.
// - The write ends by itself and busy falls to mark completion.
// - After a rewrite the program strobe stays blocked until read rises.
// - Reset input low holds the memory in reset and the reset output low.
// - Word length select low gives 12-bit words, high gives 10-bit words.
// - Sixteen words are held, chosen by four parallel address inputs.
// - Erase and write of one word complete within one second.

`define CLK_HZ 20000000
`define T_SETTLE_S 10
`define T_FIRST_BIT_US 50
`define T_PROG_S 1
`define SETTLE_CYC (`T_SETTLE_S * `CLK_HZ)
`define FIRST_BIT_CYC ((`T_FIRST_BIT_US * (`CLK_HZ / 1000000)) + 1)
`define ERASE_CYC ((`T_PROG_S * `CLK_HZ) / 4)
`define WRITE_CYC ((`T_PROG_S * `CLK_HZ) / 4)

`define WORD_LEN_SHORT 4'hA
`define WORD_LEN_LONG 4'hC

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LAST 8'h08

`define CTRL_RESET 1'h1
`define CTRL_ENABLE_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_READ_BIT 1
`define STAT_BLOCK_BIT 2
`define STAT_LONG_BIT 3
`define STAT_ADDR_LSB 4
`define STAT_HOLD_BIT 8
`endif

/* src/nv_access_pkg.sv */
package nv_access_pkg;
  typedef logic [11:0] word_t;
  typedef logic [3:0] addr_t;
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_shift_in,
    st_write
  } state_t;
endpackage

/* src/nv_array_if.sv */
`timescale 1ns/1ps
interface nv_array_if;
  logic we;
  nv_access_pkg::addr_t waddr;
  nv_access_pkg::word_t wdata;
  nv_access_pkg::addr_t raddr;
  nv_access_pkg::word_t rdata;
  modport owner (output we, output waddr, output wdata, output raddr,
                 input rdata);
  modport store (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end
endmodule // pin_sync

/* src/nv_word_array.sv */
`timescale 1ns/1ps
module nv_word_array (
  input wire logic clk_i,
  nv_array_if.store port
);
  // No reset here: the contents model nonvolatile cells and must survive it.
  nv_access_pkg::word_t mem [16];

  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata = mem[port.raddr];
endmodule // nv_word_array

/* src/nv_word_access.sv */
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "nv_access_regs.svh"
module nv_word_access #(
  parameter int unsigned SETTLE_CYC = `SETTLE_CYC,
  parameter int unsigned ERASE_CYC = `ERASE_CYC,
  parameter int unsigned WRITE_CYC = `WRITE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] word_addr_i,
  input wire logic read_strobe_n_i,
  input wire logic program_trigger_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_data_in_i,
  input wire logic word_len_sel_n_i,
  input wire logic reset_in_n_i,
  output logic data_out_o,
  output logic data_oe_o,
  output logic busy_o,
  output logic reset_out_n_o
);
  localparam int unsigned FIRST_BIT_CYC = `FIRST_BIT_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [9:0] pins_s;
  logic [3:0] addr_s;
  logic read_n_s;
  logic prog_n_s;
  logic shclk_s;
  logic din_s;
  logic len_n_s;
  logic rin_n_s;

  pin_sync #(.W(10)) u_sync (
    .clk_i(clk_i),
    .d_i({word_addr_i, read_strobe_n_i, program_trigger_n_i, shift_clk_i,
          serial_data_in_i, word_len_sel_n_i, reset_in_n_i}),
    .q_o(pins_s)
  );

  assign addr_s = pins_s[9:6];
  assign read_n_s = pins_s[5];
  assign prog_n_s = pins_s[4];
  assign shclk_s = pins_s[3];
  assign din_s = pins_s[2];
  assign len_n_s = pins_s[1];
  assign rin_n_s = pins_s[0];

  logic read_n_q;
  logic prog_n_q;
  logic shclk_q;
  logic hold;
  logic read_fall;
  logic read_rise;
  logic prog_fall;
  logic shclk_fall;

  // Reset input low keeps the pin-side access logic in reset; the Wishbone registers keep running.
  assign hold = rst_i | ~rin_n_s;

  always_ff @(posedge clk_i) begin
    if (hold) begin
      read_n_q <= 1'b1;
      prog_n_q <= 1'b1;
      shclk_q <= 1'b0;
    end else begin
      read_n_q <= read_n_s;
      prog_n_q <= prog_n_s;
      shclk_q <= shclk_s;
    end
  end

  assign read_fall = read_n_q & ~read_n_s;
  assign read_rise = ~read_n_q & read_n_s;
  assign prog_fall = prog_n_q & ~prog_n_s;
  assign shclk_fall = shclk_q & ~shclk_s;

  always_ff @(posedge clk_i) begin
    if (hold) begin
      reset_out_n_o <= 1'b0;
    end else begin
      reset_out_n_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file over classic Wishbone.

  logic enable;
  logic blocked;
  nv_access_pkg::state_t state;
  nv_access_pkg::addr_t addr_q;
  nv_access_pkg::word_t last_word;
  logic long_q;
  logic wb_req;
  logic [31:0] next_rdata;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= `CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `REG_CTRL) begin
      enable <= wb_dat_i[`CTRL_ENABLE_BIT];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `REG_CTRL: begin
        next_rdata[`CTRL_ENABLE_BIT] = enable;
      end
      `REG_STATUS: begin
        next_rdata[`STAT_BUSY_BIT] = busy_o;
        next_rdata[`STAT_READ_BIT] = (state == nv_access_pkg::st_read);
        next_rdata[`STAT_BLOCK_BIT] = blocked;
        next_rdata[`STAT_LONG_BIT] = long_q;
        next_rdata[`STAT_ADDR_LSB +: 4] = addr_q;
        next_rdata[`STAT_HOLD_BIT] = hold;
      end
      `REG_LAST: begin
        next_rdata[11:0] = last_word;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read and rewrite sequencing.

  nv_array_if arr ();

  nv_word_array u_array (
    .clk_i(clk_i),
    .port(arr.store)
  );

  logic [31:0] cnt;
  logic [31:0] wcnt;
  logic [3:0] bit_idx;
  logic [3:0] word_len;
  logic settled;
  logic data_window;
  logic erase_done;
  nv_access_pkg::word_t shreg;

  // Counting from the start edge; it saturates so a long hold cannot wrap.
  assign settled = (cnt >= SETTLE_CYC);
  assign data_window = (cnt >= FIRST_BIT_CYC);
  assign erase_done = (cnt >= ERASE_CYC);
  assign word_len = long_q ? `WORD_LEN_LONG : `WORD_LEN_SHORT;

  assign arr.raddr = addr_q;
  assign arr.waddr = addr_q;
  assign arr.wdata = shreg;
  assign arr.we = (state == nv_access_pkg::st_write) &&
                  (wcnt == WRITE_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (hold) begin
      state <= nv_access_pkg::st_idle;
      cnt <= 32'h0000_0000;
      wcnt <= 32'h0000_0000;
      bit_idx <= 4'h0;
      addr_q <= 4'h0;
      long_q <= 1'b0;
      shreg <= 12'h000;
    end else begin
      if (!settled) begin
        cnt <= cnt + 32'h0000_0001;
      end
      case (state)
        nv_access_pkg::st_idle: begin
          cnt <= 32'h0000_0000;
          bit_idx <= 4'h0;
          addr_q <= addr_s;
          long_q <= ~len_n_s;
          if (enable && read_fall) begin
            state <= nv_access_pkg::st_read;
          end else if (enable && prog_fall && !blocked) begin
            state <= nv_access_pkg::st_shift_in;
            shreg <= 12'h000;
          end
        end
        nv_access_pkg::st_read: begin
          if (!settled) begin
            addr_q <= addr_s;
          end
          if (shclk_fall && data_window && bit_idx < word_len) begin
            bit_idx <= bit_idx + 4'h1;
          end
          if (read_rise) begin
            state <= nv_access_pkg::st_idle;
          end
        end
        nv_access_pkg::st_shift_in: begin
          // Address and strobes are not looked at while busy.
          if (shclk_fall && data_window && bit_idx < word_len) begin
            shreg[bit_idx] <= din_s;
            bit_idx <= bit_idx + 4'h1;
          end
          if (bit_idx == word_len && erase_done) begin
            state <= nv_access_pkg::st_write;
            wcnt <= 32'h0000_0000;
          end
        end
        nv_access_pkg::st_write: begin
          wcnt <= wcnt + 32'h0000_0001;
          if (wcnt == WRITE_CYC - 1) begin
            state <= nv_access_pkg::st_idle;
          end
        end
        default: begin
          state <= nv_access_pkg::st_idle;
        end
      endcase
    end
  end

  // Set wins over the read-edge release so a finished rewrite always locks.
  always_ff @(posedge clk_i) begin
    if (hold) begin
      blocked <= 1'b0;
    end else if (arr.we) begin
      blocked <= 1'b1;
    end else if (read_rise) begin
      blocked <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (hold) begin
      last_word <= 12'h000;
    end else if (arr.we) begin
      last_word <= shreg;
    end else if (state == nv_access_pkg::st_read && read_rise) begin
      last_word <= arr.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  assign busy_o = (state == nv_access_pkg::st_shift_in) ||
                  (state == nv_access_pkg::st_write);

  always_ff @(posedge clk_i) begin
    if (hold) begin
      data_oe_o <= 1'b0;
      data_out_o <= 1'b0;
    end else if (state == nv_access_pkg::st_read) begin
      data_oe_o <= ~read_rise;
      if (data_window && bit_idx < word_len) begin
        data_out_o <= arr.rdata[bit_idx];
      end else begin
        data_out_o <= 1'b0;
      end
    end else begin
      data_oe_o <= 1'b0;
      data_out_o <= 1'b0;
    end
  end
endmodule // nv_word_access

/* tb/nv_monitor.sv */
`timescale 1ns/1ps
module nv_monitor #(
  parameter int unsigned WRITE_CYC = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic read_strobe_n_i,
  input wire logic shift_clk_i,
  input wire logic reset_in_n_i,
  input wire logic data_out_o,
  input wire logic data_oe_o,
  input wire logic busy_o,
  input wire logic reset_out_n_o
);
  logic [10:0] rc;
  logic [3:0] sc;
  logic [15:0] bl;
  logic blk;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycle distances are counted here so the properties stay short.
  always_ff @(posedge clk_i) begin
    if (!data_oe_o) rc <= 11'h000;
    else if (rc != 11'h7FF) rc <= rc + 11'h001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || $fell(shift_clk_i)) sc <= 4'h0;
    else if (sc != 4'hF) sc <= sc + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!busy_o) bl <= 16'h0000;
    else bl <= bl + 16'h0001;
  end
  // Clearing on the raw pin edge is looser than the synced release.
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_out_n_o || $rose(read_strobe_n_i)) blk <= 1'b0;
    else if ($fell(busy_o)) blk <= 1'b1;
  end
  ////////////////////////////////////////
  AST_RST_OUT: assert property (
    !reset_in_n_i [*3] |=> !reset_out_n_o && !busy_o) else $error("rst");
  AST_OE_HOLD: assert property (
    data_oe_o && !read_strobe_n_i && reset_in_n_i |=> data_oe_o)
    else $error("oe lost");
  AST_OE_DROP: assert property (
    read_strobe_n_i [*5] |-> !data_oe_o) else $error("oe stuck");
  AST_BUSY_NO_OE: assert property (
    busy_o |-> !data_oe_o) else $error("read while busy");
  AST_FIRST_BIT: assert property (
    rc > 11'h001 && rc < 11'h3DE |-> $stable(data_out_o))
    else $error("early bit");
  AST_SHIFT: assert property (
    data_oe_o && rc > 11'h3F2 && $changed(data_out_o) |-> sc < 4'h6)
    else $error("bit moved without shift");
  AST_WRITE_MIN: assert property (
    $fell(busy_o) && reset_out_n_o |-> bl > 1000 + WRITE_CYC)
    else $error("write too short");
  AST_BLOCK: assert property (
    blk |-> !busy_o) else $error("retrigger");
  cover property ($fell(busy_o));
  cover property ($fell(data_oe_o));
  cover property (!reset_out_n_o);
endmodule // nv_monitor
bind nv_word_access nv_monitor #(.WRITE_CYC(WRITE_CYC)) nv_monitor_inst (
  .clk_i, .rst_i, .read_strobe_n_i, .shift_clk_i, .reset_in_n_i,
  .data_out_o, .data_oe_o, .busy_o, .reset_out_n_o);

/* tb/ctl.sv */
`timescale 1ns/1ps
module ctl (
  input wire logic clk_i,
  input wire logic dq_i,
  output logic [3:0] adr_o,
  output logic rd_n_o,
  output logic pg_n_o,
  output logic sck_o,
  output logic di_o
);
  // The link clock stands low between frames.
  initial begin
    adr_o = 4'h0;
    rd_n_o = 1'b1;
    pg_n_o = 1'b1;
    sck_o = 1'b0;
    di_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  task automatic go(input logic [3:0] a, input logic rd);
    tick(1);
    adr_o <= a;
    if (rd) rd_n_o <= 1'b1;
    else pg_n_o <= 1'b1;
    tick(2000);
    if (rd) rd_n_o <= 1'b0;
    else pg_n_o <= 1'b0;
    tick(1010);
  endtask
  // Data moves with the rising clock edge, so it is steady at the fall.
  task automatic pulse(input logic d, output logic q);
    sck_o <= 1'b1;
    di_o <= d;
    tick(2);
    q = dq_i;
    tick(2);
    sck_o <= 1'b0;
    tick(4);
  endtask
  task automatic rw(input int n, input logic [15:0] w,
      output logic [15:0] q);
    logic b;
    q = 16'h0000;
    for (int i = 0; i < n; i++) begin
      pulse(w[i], b);
      q[i] = b;
    end
    di_o <= ~di_o;
    tick(6);
  endtask
  task automatic rd_end();
    rd_n_o <= 1'b1;
    tick(6);
  endtask
endmodule // ctl

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic word_len_sel_n_i = 1'b0;
  logic reset_in_n_i = 1'b1;
  logic [31:0] wb_dat_o;
  logic [3:0] word_addr_i;
  logic wb_ack_o, read_strobe_n_i, program_trigger_n_i, shift_clk_i;
  logic serial_data_in_i, data_out_o, data_oe_o, busy_o, reset_out_n_o;
  logic [31:0] q;
  logic [15:0] w;
  int err_total = 0;
  int samples_checked = 0;
  // Short counts keep the run small; the monitor gets the same WRITE_CYC.
  nv_word_access #(.SETTLE_CYC(2000), .ERASE_CYC(50), .WRITE_CYC(50))
    nv_word_access_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .word_addr_i,
    .read_strobe_n_i, .program_trigger_n_i, .shift_clk_i,
    .serial_data_in_i, .word_len_sel_n_i, .reset_in_n_i, .data_out_o,
    .data_oe_o, .busy_o, .reset_out_n_o);
  ctl ctl_inst (.clk_i, .dq_i(data_out_o), .adr_o(word_addr_i),
    .rd_n_o(read_strobe_n_i), .pg_n_o(program_trigger_n_i),
    .sck_o(shift_clk_i), .di_o(serial_data_in_i));
  initial forever #25 clk_i = ~clk_i;
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("TB: %0d bad of %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Ack and read data are taken at the very edge that samples ack high.
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      $display("BAD %0t no ack", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (busy_o !== 1'b0 && n < 3000);
    chk(32'(busy_o), 32'h0);
  endtask
  ////////////////////////////////////////
  task automatic t_bus();
    bus(1'b0, 8'h00, 32'h00000000);
    chk(q, 32'h00000001);
    bus(1'b1, 8'h00, 32'h00000000);
    bus(1'b0, 8'h00, 32'h00000000);
    chk(q, 32'h00000000);
    bus(1'b1, 8'h00, 32'h00000001);
    bus(1'b0, 8'h00, 32'h00000000);
    chk(q, 32'h00000001);
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    bus(1'b0, 8'hFC, 32'h00000000);
    chk(q, 32'h00000000);
    bus(1'b0, 8'h04, 32'h00000000);
    chk(q & 32'h00000009, 32'h00000008);
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    reset_in_n_i <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk(32'(reset_out_n_o), 32'h0);
    bus(1'b0, 8'h04, 32'h00000000);
    chk(q & 32'h00000100, 32'h00000100);
    @(posedge clk_i);
    reset_in_n_i <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk(32'(reset_out_n_o), 32'h1);
  endtask
  // A read strobe and a new address during busy must both be ignored.
  task automatic t_write();
    ctl_inst.go(4'hF, 1'b0);
    @(negedge clk_i);
    chk(32'(busy_o), 32'h1);
    ctl_inst.go(4'h3, 1'b1);
    @(negedge clk_i);
    chk({30'h0, data_oe_o, busy_o}, 32'h1);
    bus(1'b0, 8'h04, 32'h00000000);
    chk(q & 32'h000000F0, 32'h000000F0);
    ctl_inst.rw(12, 16'hFA5C, w);
    idle();
    bus(1'b0, 8'h08, 32'h00000000);
    chk(q, 32'h00000A5C);
  endtask
  task automatic t_block();
    ctl_inst.go(4'hF, 1'b0);
    @(negedge clk_i);
    chk(32'(busy_o), 32'h0);
    bus(1'b0, 8'h04, 32'h00000000);
    chk(q & 32'h00000004, 32'h00000004);
  endtask
  task automatic t_read();
    ctl_inst.go(4'hF, 1'b1);
    @(negedge clk_i);
    chk(32'(data_oe_o), 32'h1);
    ctl_inst.rw(14, 16'h0000, w);
    ctl_inst.rd_end();
    @(negedge clk_i);
    chk({data_oe_o, 15'h0, w}, 32'h00000A5C);
  endtask
  task automatic t_short();
    @(posedge clk_i);
    word_len_sel_n_i <= 1'b1;
    ctl_inst.go(4'h0, 1'b0);
    ctl_inst.rw(10, 16'hFFFF, w);
    idle();
    ctl_inst.go(4'h0, 1'b1);
    ctl_inst.rw(12, 16'h0000, w);
    ctl_inst.rd_end();
    chk({16'h0, w}, 32'h000003FF);
    ctl_inst.go(4'hF, 1'b1);
    ctl_inst.rw(10, 16'h0000, w);
    ctl_inst.rd_end();
    chk({16'h0, w}, 32'h0000025C);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_bus();
    t_reset();
    t_write();
    t_block();
    t_read();
    t_short();
    tally_and_finish();
  end
endmodule // tb
